// ==== src/pvsir_cfg.svh ====
// register map, field positions, reset values and frame constants for the vendor status block
`ifndef PVSIR_CFG_SVH
`define PVSIR_CFG_SVH

// register addresses on the management port
`define PVSIR_REG_LINK 5'h13
`define PVSIR_REG_SYMERR 5'h15
`define PVSIR_REG_EVENT 5'h1B
`define PVSIR_REG_XOVER 5'h1C
`define PVSIR_REG_PHYCTL 5'h1F

// field positions
`define PVSIR_LINK1000_BIT 2
`define PVSIR_LINK100_BIT 1
`define PVSIR_EVT_EN_MSB 15
`define PVSIR_EVT_EN_LSB 8
`define PVSIR_EVT_FLAG_MSB 7
`define PVSIR_EVT_FLAG_LSB 0
`define PVSIR_MDI_SET_BIT 7
`define PVSIR_SWAPOFF_BIT 6
`define PVSIR_PCS_LB_BIT 0
`define PVSIR_INT_POL_BIT 14
`define PVSIR_JAB_EN_BIT 9

// reset values and the symbol error count limit
`define PVSIR_SYMERR_RST 16'h0000
`define PVSIR_SYMERR_MAX 16'hFFFF
`define PVSIR_EVT_EN_RST 8'h00
`define PVSIR_EVT_FLAG_RST 8'h00
`define PVSIR_MDI_SET_RST 1'b0
`define PVSIR_SWAPOFF_RST 1'b0
`define PVSIR_PCS_LB_RST 1'b0
`define PVSIR_INT_POL_RST 1'b0
`define PVSIR_JAB_EN_RST 1'b1

// management frame
`define PVSIR_PREAMBLE_BITS 6'h20
`define PVSIR_OP_READ 2'h2
`define PVSIR_OP_WRITE 2'h1
`define PVSIR_HDR_LAST 4'hB
`define PVSIR_DATA_LAST 4'hF

`endif

// ==== src/pvsir_pkg.sv ====
// types shared by the vendor status register block
package pvsir_pkg;
    typedef enum logic [2:0] {
        PVSIR_PRE,
        PVSIR_START,
        PVSIR_HDR,
        PVSIR_TA,
        PVSIR_DATA
    } pvsir_mdio_state_t;
endpackage

// ==== src/pvsir_regs.sv ====
// vendor status, event flag and control registers behind a management serial slave
`timescale 1ns/1ps
`default_nettype none
`include "pvsir_cfg.svh"

module pvsir_regs
    import pvsir_pkg::*;
#(
    parameter int unsigned PHY_ADDR = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // management serial port
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // link status and error events from the data path
    input wire logic link_good_1000,
    input wire logic link_good_100,
    input wire logic receive_symbol_error_frame,
    input wire logic jabber_evt,
    input wire logic rx_error_evt,
    input wire logic page_rx_evt,
    input wire logic par_det_fault_evt,
    input wire logic partner_ack_evt,
    input wire logic link_down_evt,
    input wire logic remote_fault_evt,
    input wire logic link_up_evt,
    // controls to the data path
    output logic auto_crossover_en,
    output logic force_mdi,
    output logic pcs_loopback,
    output logic jabber_count_en,
    output logic intr
);

    if (PHY_ADDR > 31) begin : g_bad_addr
        $error("PHY_ADDR must fit in five bits");
    end

    logic mdc_s1_r, mdc_s2_r, mdc_d_r, mdio_s1_r, mdio_s2_r;
    logic mdc_rise;
    pvsir_mdio_state_t state_r;
    logic [5:0] pre_cnt_r;
    logic [3:0] bit_cnt_r;
    logic [11:0] hdr_r;
    logic [11:0] hdr_nxt;
    logic [15:0] dsh_r;
    logic rd_own_r, wr_own_r, mdio_o_r, mdio_oe_r;
    logic addr_hit, hdr_done, rd_hit, wr_done;
    logic [4:0] rd_reg, wr_reg;
    logic [15:0] wr_data, rd_data;
    logic [1:0] stat_r;
    logic [15:0] sym_cnt_r;
    logic [7:0] evt_en_r, flags_r, evt_vec;
    logic mdi_set_r, swapoff_r, pcs_lb_r, int_pol_r, jab_en_r;
    logic auto_xover_r, force_mdi_r, intr_r;
    logic any_evt;

    // both lines share the same delay so bit and edge stay aligned
    always_ff @(posedge clock) begin
        if (srst) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_d_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
        end else begin
            mdc_s1_r <= mdc;
            mdc_s2_r <= mdc_s1_r;
            mdc_d_r <= mdc_s2_r;
            mdio_s1_r <= mdio_i;
            mdio_s2_r <= mdio_s1_r;
        end
    end

    assign mdc_rise = mdc_s2_r & ~mdc_d_r;
    assign hdr_nxt = {hdr_r[10:0], mdio_s2_r};
    assign addr_hit = (hdr_nxt[9:5] == PHY_ADDR[4:0]);
    assign hdr_done = mdc_rise && (state_r == PVSIR_HDR) && (bit_cnt_r == `PVSIR_HDR_LAST);
    assign rd_hit = hdr_done && addr_hit && (hdr_nxt[11:10] == `PVSIR_OP_READ);
    assign rd_reg = hdr_nxt[4:0];
    assign wr_reg = hdr_r[4:0];
    assign wr_data = {dsh_r[14:0], mdio_s2_r};
    assign wr_done = mdc_rise && (state_r == PVSIR_DATA) && (bit_cnt_r == `PVSIR_DATA_LAST) && wr_own_r;

    // read data is taken at the end of the header, before turnaround
    always_comb begin
        rd_data = 16'h0000;
        case (rd_reg)
            `PVSIR_REG_LINK: begin
                rd_data[`PVSIR_LINK1000_BIT] = stat_r[1];
                rd_data[`PVSIR_LINK100_BIT] = stat_r[0];
            end
            `PVSIR_REG_SYMERR: rd_data = sym_cnt_r;
            `PVSIR_REG_EVENT: begin
                rd_data[`PVSIR_EVT_EN_MSB:`PVSIR_EVT_EN_LSB] = evt_en_r;
                rd_data[`PVSIR_EVT_FLAG_MSB:`PVSIR_EVT_FLAG_LSB] = flags_r;
            end
            `PVSIR_REG_XOVER: begin
                rd_data[`PVSIR_MDI_SET_BIT] = mdi_set_r;
                rd_data[`PVSIR_SWAPOFF_BIT] = swapoff_r;
                rd_data[`PVSIR_PCS_LB_BIT] = pcs_lb_r;
            end
            `PVSIR_REG_PHYCTL: begin
                rd_data[`PVSIR_INT_POL_BIT] = int_pol_r;
                rd_data[`PVSIR_JAB_EN_BIT] = jab_en_r;
            end
            default: rd_data = 16'h0000;
        endcase
    end

    // frame tracker: preamble, start, op/phy/reg, turnaround, data
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= PVSIR_PRE;
            pre_cnt_r <= 6'h00;
            bit_cnt_r <= 4'h0;
            hdr_r <= 12'h000;
            dsh_r <= 16'h0000;
            rd_own_r <= 1'b0;
            wr_own_r <= 1'b0;
            mdio_o_r <= 1'b1;
            mdio_oe_r <= 1'b0;
        end else if (mdc_rise) begin
            case (state_r)
                PVSIR_PRE: begin
                    if (mdio_s2_r) begin
                        if (pre_cnt_r != `PVSIR_PREAMBLE_BITS) begin
                            pre_cnt_r <= pre_cnt_r + 6'h01;
                        end
                    end else if (pre_cnt_r == `PVSIR_PREAMBLE_BITS) begin
                        state_r <= PVSIR_START;
                        pre_cnt_r <= 6'h00;
                    end else begin
                        pre_cnt_r <= 6'h00;
                    end
                end
                PVSIR_START: begin
                    bit_cnt_r <= 4'h0;
                    state_r <= mdio_s2_r ? PVSIR_HDR : PVSIR_PRE;
                end
                PVSIR_HDR: begin
                    hdr_r <= hdr_nxt;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (hdr_done) begin
                        state_r <= PVSIR_TA;
                        bit_cnt_r <= 4'h0;
                        rd_own_r <= rd_hit;
                        wr_own_r <= addr_hit && (hdr_nxt[11:10] == `PVSIR_OP_WRITE);
                        dsh_r <= rd_data;
                    end
                end
                PVSIR_TA: begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'h0) begin
                        mdio_oe_r <= rd_own_r;
                        mdio_o_r <= 1'b0;
                    end else begin
                        state_r <= PVSIR_DATA;
                        bit_cnt_r <= 4'h0;
                        mdio_o_r <= dsh_r[15];
                        dsh_r <= {dsh_r[14:0], 1'b0};
                    end
                end
                PVSIR_DATA: begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    mdio_o_r <= dsh_r[15];
                    dsh_r <= wr_data;
                    if (bit_cnt_r == `PVSIR_DATA_LAST) begin
                        state_r <= PVSIR_PRE;
                        bit_cnt_r <= 4'h0;
                        mdio_oe_r <= 1'b0;
                        rd_own_r <= 1'b0;
                        wr_own_r <= 1'b0;
                    end
                end
                default: state_r <= PVSIR_PRE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            stat_r <= 2'h0;
        end else begin
            stat_r <= {link_good_1000, link_good_100};
        end
    end

    // saturates rather than wrapping so a slow poller still sees a burst
    always_ff @(posedge clock) begin
        if (srst) begin
            sym_cnt_r <= `PVSIR_SYMERR_RST;
        end else if (rd_hit && (rd_reg == `PVSIR_REG_SYMERR)) begin
            sym_cnt_r <= {15'h0000, receive_symbol_error_frame};
        end else if (receive_symbol_error_frame && (sym_cnt_r != `PVSIR_SYMERR_MAX)) begin
            sym_cnt_r <= sym_cnt_r + 16'h0001;
        end
    end

    assign evt_vec = {jabber_evt, rx_error_evt, page_rx_evt, par_det_fault_evt,
                      partner_ack_evt, link_down_evt, remote_fault_evt, link_up_evt};

    always_ff @(posedge clock) begin
        if (srst) begin
            evt_en_r <= `PVSIR_EVT_EN_RST;
        end else if (wr_done && (wr_reg == `PVSIR_REG_EVENT)) begin
            evt_en_r <= wr_data[`PVSIR_EVT_EN_MSB:`PVSIR_EVT_EN_LSB];
        end
    end

    // an event in the clearing cycle survives the read
    always_ff @(posedge clock) begin
        if (srst) begin
            flags_r <= `PVSIR_EVT_FLAG_RST;
        end else if (rd_hit && (rd_reg == `PVSIR_REG_EVENT)) begin
            flags_r <= evt_vec;
        end else begin
            flags_r <= flags_r | evt_vec;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mdi_set_r <= `PVSIR_MDI_SET_RST;
            swapoff_r <= `PVSIR_SWAPOFF_RST;
            pcs_lb_r <= `PVSIR_PCS_LB_RST;
        end else if (wr_done && (wr_reg == `PVSIR_REG_XOVER)) begin
            mdi_set_r <= wr_data[`PVSIR_MDI_SET_BIT];
            swapoff_r <= wr_data[`PVSIR_SWAPOFF_BIT];
            pcs_lb_r <= wr_data[`PVSIR_PCS_LB_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            int_pol_r <= `PVSIR_INT_POL_RST;
            jab_en_r <= `PVSIR_JAB_EN_RST;
        end else if (wr_done && (wr_reg == `PVSIR_REG_PHYCTL)) begin
            int_pol_r <= wr_data[`PVSIR_INT_POL_BIT];
            jab_en_r <= wr_data[`PVSIR_JAB_EN_BIT];
        end
    end

    // manual select only matters once auto crossover is off
    always_ff @(posedge clock) begin
        if (srst) begin
            auto_xover_r <= 1'b1;
            force_mdi_r <= 1'b0;
        end else begin
            auto_xover_r <= ~swapoff_r;
            force_mdi_r <= swapoff_r & mdi_set_r;
        end
    end

    assign any_evt = |(flags_r & evt_en_r);

    // idle level follows polarity; reset polarity is active low so idle high
    always_ff @(posedge clock) begin
        if (srst) begin
            intr_r <= 1'b1;
        end else begin
            intr_r <= int_pol_r ? any_evt : ~any_evt;
        end
    end

    assign mdio_o = mdio_o_r;
    assign mdio_oe = mdio_oe_r;
    assign auto_crossover_en = auto_xover_r;
    assign force_mdi = force_mdi_r;
    assign pcs_loopback = pcs_lb_r;
    assign jabber_count_en = jab_en_r;
    assign intr = intr_r;

    property p_link1000;
        @(posedge clock) disable iff (srst) link_good_1000 |=> stat_r[1];
    endproperty
    a_link1000: assert property (p_link1000) else $error("1000 link status not shown");

    property p_link100;
        @(posedge clock) disable iff (srst) !link_good_100 |=> !stat_r[0];
    endproperty
    a_link100: assert property (p_link100) else $error("100 link status stuck good");

    property p_symerr_clr;
        @(posedge clock) disable iff (srst)
            (rd_hit && (rd_reg == `PVSIR_REG_SYMERR) && !receive_symbol_error_frame) |=> (sym_cnt_r == 16'h0000);
    endproperty
    a_symerr_clr: assert property (p_symerr_clr) else $error("error count not cleared by read");

    for (genvar gi = 0; gi < 8; gi++) begin : g_evt_chk
        property p_evt_set;
            @(posedge clock) disable iff (srst) evt_vec[gi] |=> flags_r[gi] ##1 (flags_r[gi] || $past(rd_hit));
        endproperty
        a_evt_set: assert property (p_evt_set) else $error("event flag lost");
    end

    property p_flag_clr;
        @(posedge clock) disable iff (srst)
            (rd_hit && (rd_reg == `PVSIR_REG_EVENT) && (evt_vec == 8'h00)) |=> (flags_r == 8'h00);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("event flags not cleared by read");

    property p_xover;
        @(posedge clock) disable iff (srst) swapoff_r [*2] |-> !auto_xover_r;
    endproperty
    a_xover: assert property (p_xover) else $error("auto crossover still on");

    property p_mdi_sel;
        @(posedge clock) disable iff (srst) (swapoff_r && !mdi_set_r) |=> !force_mdi_r;
    endproperty
    a_mdi_sel: assert property (p_mdi_sel) else $error("MDI forced while MDI-X chosen");

    property p_loop;
        @(posedge clock) disable iff (srst)
            (wr_done && (wr_reg == `PVSIR_REG_XOVER) && wr_data[`PVSIR_PCS_LB_BIT]) |=> pcs_loopback;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback select not applied");

    property p_intr_idle;
        @(posedge clock) disable iff (srst) !any_evt |=> (intr_r != $past(int_pol_r));
    endproperty
    a_intr_idle: assert property (p_intr_idle) else $error("interrupt not released");

    property p_intr_on;
        @(posedge clock) disable iff (srst)
            (link_up_evt && evt_en_r[0] && !wr_done && !rd_hit) |=> (any_evt ##1 (intr_r == $past(int_pol_r)));
    endproperty
    a_intr_on: assert property (p_intr_on) else $error("interrupt not asserted");

    property p_jab_rst;
        @(posedge clock) $fell(srst) |-> jab_en_r;
    endproperty
    a_jab_rst: assert property (p_jab_rst) else $error("jabber counter enable not set at reset");

endmodule

`default_nettype wire

// ==== test/pvsir_mdio_master.sv ====
// station manager model driving the serial management frames
`timescale 1ns/1ps
`default_nettype none
module pvsir_mdio_master (
    // system clock for pacing
    input wire logic clock,
    // block side of the data pin
    input wire logic mdio_o,
    input wire logic mdio_oe,
    // management pins
    output logic mdc,
    output logic mdio_line
);
    logic drv_en;
    logic drv_val;
    // line has a pull-up, so a released line reads one
    assign mdio_line = mdio_oe ? mdio_o : (drv_en ? drv_val : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end
    // halves of 4 clocks keep above the 3 the synchronisers need
    task automatic bit_cycle(input logic b, input logic en, output logic smp);
        drv_en = en;
        drv_val = b;
        repeat (4) @(negedge clock);
        smp = mdio_line;
        mdc = 1'b1;
        repeat (4) @(negedge clock);
        mdc = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta);
        logic [63:0] bits;
        logic s;
        bits = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            bit_cycle(bits[i], !(op == 2'h2 && i <= 17), s);
            if (i == 16) ta = s;
            if (i < 16) rd[i] = s;
        end
        drv_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the vendor status register block
`timescale 1ns/1ps
`default_nettype none
`include "pvsir_cfg.svh"
module testbench;
    localparam int PHY = 5;
    logic clock, srst, mdc, mdio_line, mdio_o, mdio_oe;
    logic lg1000, lg100, symerr;
    logic [7:0] evt;
    logic auto_x, fmdi, pcs_lb, jab_en, intr;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    pvsir_regs #(.PHY_ADDR(PHY)) dut (.clock(clock), .srst(srst), .mdc(mdc), .mdio_i(mdio_line),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .link_good_1000(lg1000), .link_good_100(lg100),
        .receive_symbol_error_frame(symerr), .jabber_evt(evt[7]), .rx_error_evt(evt[6]),
        .page_rx_evt(evt[5]), .par_det_fault_evt(evt[4]), .partner_ack_evt(evt[3]),
        .link_down_evt(evt[2]), .remote_fault_evt(evt[1]), .link_up_evt(evt[0]),
        .auto_crossover_en(auto_x), .force_mdi(fmdi), .pcs_loopback(pcs_lb),
        .jabber_count_en(jab_en), .intr(intr));
    pvsir_mdio_master sm (.clock(clock), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_line(mdio_line));
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ta;
        sm.frame(2'h2, 5'(PHY), a, 16'h0000, d, ta);
        check({15'h0, ta}, 16'h0000);
        check(d, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        logic ta;
        sm.frame(2'h1, 5'(PHY), a, d, x, ta);
        // controls lag the frame end by a few clocks
        repeat (6) @(negedge clock);
    endtask
    task automatic pulse(input logic [7:0] e, input logic s);
        evt = e;
        symerr = s;
        @(negedge clock);
        evt = 8'h00;
        symerr = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    task automatic t_reset();
        check({11'h0, auto_x, fmdi, pcs_lb, jab_en, intr}, 16'h0013);
        rdc(`PVSIR_REG_LINK, 16'h0000);
        rdc(`PVSIR_REG_SYMERR, 16'h0000);
        rdc(`PVSIR_REG_EVENT, 16'h0000);
        rdc(`PVSIR_REG_XOVER, 16'h0000);
        rdc(`PVSIR_REG_PHYCTL, 16'h0200);
    endtask
    task automatic t_link();
        lg1000 = 1'b1;
        rdc(`PVSIR_REG_LINK, 16'h0004);
        lg1000 = 1'b0;
        lg100 = 1'b1;
        rdc(`PVSIR_REG_LINK, 16'h0002);
    endtask
    task automatic t_symerr();
        repeat (3) pulse(8'h00, 1'b1);
        wr(`PVSIR_REG_SYMERR, 16'hFFFF);
        rdc(`PVSIR_REG_SYMERR, 16'h0003);
        rdc(`PVSIR_REG_SYMERR, 16'h0000);
    endtask
    task automatic t_events();
        logic [15:0] en;
        int j;
        for (int i = 0; i < 8; i++) begin
            en = 16'h0100 << i;
            j = (i + 1) % 8;
            // flag bits written high must be dropped
            wr(`PVSIR_REG_EVENT, en | 16'h00FF);
            pulse(8'h01 << j, 1'b0);
            check({15'h0, intr}, 16'h0001);
            rdc(`PVSIR_REG_EVENT, en | (16'h0001 << j));
            pulse(8'h01 << i, 1'b0);
            check({15'h0, intr}, 16'h0000);
            rdc(`PVSIR_REG_EVENT, en | (16'h0001 << i));
            check({15'h0, intr}, 16'h0001);
        end
    endtask
    task automatic t_polarity();
        wr(`PVSIR_REG_PHYCTL, 16'h4200);
        check({15'h0, intr}, 16'h0000);
        wr(`PVSIR_REG_EVENT, 16'h0100);
        pulse(8'h01, 1'b0);
        check({15'h0, intr}, 16'h0001);
        rdc(`PVSIR_REG_EVENT, 16'h0101);
        check({15'h0, intr}, 16'h0000);
        wr(`PVSIR_REG_PHYCTL, 16'h0000);
        check({14'h0, jab_en, intr}, 16'h0001);
        rdc(`PVSIR_REG_PHYCTL, 16'h0000);
    endtask
    task automatic t_xover();
        logic [15:0] x;
        logic ta;
        wr(`PVSIR_REG_XOVER, 16'h0041);
        check({13'h0, auto_x, fmdi, pcs_lb}, 16'h0001);
        wr(`PVSIR_REG_XOVER, 16'h00C0);
        check({13'h0, auto_x, fmdi, pcs_lb}, 16'h0002);
        wr(`PVSIR_REG_XOVER, 16'hFF80);
        check({13'h0, auto_x, fmdi, pcs_lb}, 16'h0004);
        rdc(`PVSIR_REG_XOVER, 16'h0080);
        // frames for another station address must neither write nor drive
        sm.frame(2'h1, 5'(PHY + 1), `PVSIR_REG_XOVER, 16'h0041, x, ta);
        repeat (6) @(negedge clock);
        check({13'h0, auto_x, fmdi, pcs_lb}, 16'h0004);
        sm.frame(2'h2, 5'(PHY + 1), `PVSIR_REG_XOVER, 16'h0000, x, ta);
        check(x, 16'hFFFF);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        lg1000 = 1'b0;
        lg100 = 1'b0;
        symerr = 1'b0;
        evt = 8'h00;
        repeat (12) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        t_reset();
        t_link();
        t_symerr();
        t_events();
        t_polarity();
        t_xover();
        report_and_stop();
    end
    // about 45 frames of 512 clocks expected
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire
